// ### src/scc_pkg.sv
// Package of constants and types for the bus clock/configuration block
package scc_pkg;
  // Register map (special function register address)
  localparam logic [7:0] SCC_ADDR_CFG       = 8'hC1;
  localparam logic [7:0] SCC_CFG_RESET      = 8'h00;
  // Field positions in the configuration register
  localparam int SCC_BIT_ENABLE   = 7;
  localparam int SCC_BIT_INHIBIT  = 6;
  localparam int SCC_BIT_BUSY     = 5;
  localparam int SCC_BIT_SDA_EXT  = 4;
  localparam int SCC_BIT_SCLTO    = 3;
  localparam int SCC_BIT_FREETO   = 2;
  localparam int SCC_BIT_SRC_HI   = 1;
  localparam int SCC_BIT_SRC_LO   = 0;
  // Writable bits mask (busy is read only)
  localparam logic [7:0] SCC_WR_MASK        = 8'hDF;
  // Bit-rate source encodings
  localparam logic [1:0] SCC_SRC_T0         = 2'h0;
  localparam logic [1:0] SCC_SRC_T1         = 2'h1;
  localparam logic [1:0] SCC_SRC_T2H        = 2'h2;
  localparam logic [1:0] SCC_SRC_T2L        = 2'h3;
  // Bus-free timeout: more than this many source periods
  localparam int SCC_FREE_PERIODS = 10;
  localparam int SCC_FREE_W       = 4;
  // SDA setup/hold, in system clock cycles, normal and extended
  localparam int SCC_SDA_HOLD_NORM = 1;
  localparam int SCC_SDA_HOLD_EXT  = 3;
  localparam int SCC_HOLD_W        = 2;
  // Link-side bus states
  typedef enum logic [1:0] {
    SCC_LINK_IDLE,
    SCC_LINK_BUSY
  } scc_link_state_t;
endpackage : scc_pkg

// ### src/scc_link_mon.sv
// Link-side START/STOP detector running on the link clock
module scc_link_mon
  import scc_pkg::*;
(
  input  wire logic i_link_clk,
  input  wire logic i_resetn,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_start_tgl,
  output logic      o_stop_tgl
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic       scl_d;
    logic       sda_d;
    logic       start_tgl;
    logic       stop_tgl;
  } scc_link_t;

  scc_link_t st;
  scc_link_t next_st;

  // Synchronise pins, then look for SDA edges while SCL is high
  always_comb begin
    next_st       = st;
    next_st.scl_s = {st.scl_s[0], i_scl};
    next_st.sda_s = {st.sda_s[0], i_sda};
    next_st.scl_d = st.scl_s[1];
    next_st.sda_d = st.sda_s[1];
    if (st.scl_s[1] && st.scl_d) begin
      if (st.sda_d && !st.sda_s[1]) begin
        next_st.start_tgl = ~st.start_tgl;
      end
      if (!st.sda_d && st.sda_s[1]) begin
        next_st.stop_tgl = ~st.stop_tgl;
      end
    end
  end

  always_ff @(posedge i_link_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
              start_tgl: 1'b0, stop_tgl: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Toggles cross to the system clock as events
  assign o_start_tgl = st.start_tgl;
  assign o_stop_tgl  = st.stop_tgl;
endmodule : scc_link_mon

// ### src/scc_config.sv
// Bus clock/configuration register and bus supervision logic
// How it works
// - Enable bit activates and monitors SDA/SCL.
// - Inhibit bit masks slave interrupts, not master.
// - Busy set on transfer, cleared STOP/free-timeout.
// - Extension bit selects long SDA setup/hold.
// - SCL high reloads timer, SCL low counts.
// - Split mode reloads only timer high byte.
// - Both lines high over 10 ticks: bus free.
// - Source select picks among four timer overflows.
module scc_config
  import scc_pkg::*;
#(
  parameter int FREE_PERIODS = SCC_FREE_PERIODS
)
(
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_link_clk,
  input  wire logic       i_sfr_wr,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_t0_ovf,
  input  wire logic       i_t1_ovf,
  input  wire logic       i_t2h_ovf,
  input  wire logic       i_t2l_ovf,
  input  wire logic       i_timer_split,
  input  wire logic       i_slave_event,
  input  wire logic       i_master_event,
  output logic            o_irq_event,
  output logic            o_timer_reload_hi,
  output logic            o_timer_reload_lo,
  output logic            o_bit_tick,
  output logic            o_monitor_active,
  output logic      [1:0] o_sda_hold_cycles,
  output logic            o_bus_free
);
  import scc_pkg::*;

  typedef struct packed {
    logic [7:0]            cfg;
    logic [1:0]            scl_s;
    logic [1:0]            sda_s;
    logic [1:0]            start_s;
    logic [1:0]            stop_s;
    logic                  start_d;
    logic                  stop_d;
    logic [SCC_FREE_W-1:0] free_cnt;
    scc_link_state_t       bus;
    logic                  tick;
    logic                  irq;
    logic                  rl_hi;
    logic                  rl_lo;
    logic                  free;
  } scc_state_t;

  scc_state_t st;
  scc_state_t next_st;

  logic start_tgl;
  logic stop_tgl;

  // START/STOP detection lives on the link clock
  scc_link_mon u_link_mon (
    .i_link_clk  (i_link_clk),
    .i_resetn    (i_resetn),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .o_start_tgl (start_tgl),
    .o_stop_tgl  (stop_tgl)
  );

  logic enable;
  logic inhibit;
  logic sda_ext;
  logic scl_to_en;
  logic free_to_en;
  logic [1:0] src_sel;
  logic tick_sel;
  logic start_ev;
  logic stop_ev;
  logic both_high;

  // Field decode of the configuration register
  always_comb begin
    enable     = st.cfg[SCC_BIT_ENABLE];
    inhibit    = st.cfg[SCC_BIT_INHIBIT];
    sda_ext    = st.cfg[SCC_BIT_SDA_EXT];
    scl_to_en  = st.cfg[SCC_BIT_SCLTO];
    free_to_en = st.cfg[SCC_BIT_FREETO];
    src_sel    = st.cfg[SCC_BIT_SRC_HI:SCC_BIT_SRC_LO];
    start_ev   = st.start_s[1] ^ st.start_d;
    stop_ev    = st.stop_s[1] ^ st.stop_d;
    both_high  = st.scl_s[1] && st.sda_s[1];
  end

  // Bit-rate tick multiplexer
  always_comb begin
    unique case (src_sel)
      SCC_SRC_T0:  tick_sel = i_t0_ovf;
      SCC_SRC_T1:  tick_sel = i_t1_ovf;
      SCC_SRC_T2H: tick_sel = i_t2h_ovf;
      SCC_SRC_T2L: tick_sel = i_t2l_ovf;
    endcase
  end

  // Next-state logic for register, supervision and busy tracking
  always_comb begin
    next_st         = st;
    next_st.scl_s   = {st.scl_s[0], i_scl};
    next_st.sda_s   = {st.sda_s[0], i_sda};
    next_st.start_s = {st.start_s[0], start_tgl};
    next_st.stop_s  = {st.stop_s[0], stop_tgl};
    next_st.start_d = st.start_s[1];
    next_st.stop_d  = st.stop_s[1];
    next_st.tick    = tick_sel;
    // Busy is never written by software
    if (i_sfr_wr && i_sfr_addr == SCC_ADDR_CFG) begin
      next_st.cfg = (i_sfr_wdata & SCC_WR_MASK)
                  | (st.cfg & ~SCC_WR_MASK);
    end
    // Counter restarts whenever either line is low
    if (!enable || !free_to_en || !both_high) begin
      next_st.free_cnt = '0;
      next_st.free     = 1'b0;
    end else if (tick_sel && !st.free) begin
      if (32'(st.free_cnt) >= FREE_PERIODS) begin
        next_st.free = 1'b1;
      end else begin
        next_st.free_cnt = st.free_cnt + SCC_FREE_W'(1);
      end
    end
    // Busy: set by START or any line low, cleared by STOP or free
    if (!enable) begin
      next_st.bus = SCC_LINK_IDLE;
    end else begin
      unique case (st.bus)
        SCC_LINK_IDLE: begin
          if (start_ev || !both_high) begin
            next_st.bus = SCC_LINK_BUSY;
          end
        end
        SCC_LINK_BUSY: begin
          if (stop_ev || (st.free && free_to_en)) begin
            next_st.bus = SCC_LINK_IDLE;
          end
        end
        default: next_st.bus = SCC_LINK_IDLE;
      endcase
    end
    // Slave events are dropped while inhibited
    next_st.irq = enable && (i_master_event
                  || (i_slave_event && !inhibit));
    // Timer reload control for SCL-low supervision
    next_st.rl_hi = enable && scl_to_en && st.scl_s[1];
    next_st.rl_lo = enable && scl_to_en && st.scl_s[1]
                    && !i_timer_split;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{cfg: SCC_CFG_RESET, scl_s: 2'h3, sda_s: 2'h3,
              start_s: 2'h0, stop_s: 2'h0, start_d: 1'b0,
              stop_d: 1'b0, free_cnt: '0, bus: SCC_LINK_IDLE,
              tick: 1'b0, irq: 1'b0, rl_hi: 1'b0, rl_lo: 1'b0,
              free: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Register read-back shows live busy state
  always_comb begin
    o_sfr_rdata = st.cfg;
    o_sfr_rdata[SCC_BIT_BUSY] = (st.bus == SCC_LINK_BUSY);
  end

  // Extended hold uses more system cycles on SDA
  assign o_sda_hold_cycles = sda_ext ? SCC_HOLD_W'(SCC_SDA_HOLD_EXT)
                           : SCC_HOLD_W'(SCC_SDA_HOLD_NORM);
  assign o_monitor_active  = enable;
  assign o_irq_event       = st.irq;
  assign o_timer_reload_hi = st.rl_hi;
  assign o_timer_reload_lo = st.rl_lo;
  assign o_bit_tick        = st.tick;
  assign o_bus_free        = st.free;

  // Inhibited slave event alone never raises an interrupt
  a_inhibit_slave: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (inhibit && i_slave_event && !i_master_event) |=> !o_irq_event)
    else $error("slave event passed while inhibited");

  // Master events pass regardless of inhibit
  a_master_pass: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (enable && i_master_event) |=> o_irq_event)
    else $error("master event lost");

  // SCL high with supervision forces high byte reload
  a_reload_high: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (enable && scl_to_en && st.scl_s[1]) |=> o_timer_reload_hi)
    else $error("timer not held in reload");

  // SCL low lets the timer count
  a_count_low: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !st.scl_s[1] |=> !o_timer_reload_hi && !o_timer_reload_lo)
    else $error("timer held while SCL low");

  // Split mode leaves low byte free
  a_split_low: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_timer_split |=> !o_timer_reload_lo)
    else $error("low byte reloaded in split mode");

  // Free flag needs both lines high, counter restarts on low
  a_free_restart: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !both_high |=> st.free_cnt == '0 && !o_bus_free)
    else $error("free counter not restarted");

  // Free flag only after the full count of ticks
  a_free_count: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(o_bus_free) |-> 32'($past(st.free_cnt)) == FREE_PERIODS)
    else $error("bus free too early");

  // Busy clears one cycle after a STOP
  a_busy_stop: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (enable && stop_ev && st.bus == SCC_LINK_BUSY)
      |=> st.bus == SCC_LINK_IDLE)
    else $error("busy not cleared by STOP");

  // Disabled interface is idle
  a_disabled_idle: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !enable |=> st.bus == SCC_LINK_IDLE)
    else $error("busy while disabled");

  // Tick follows the selected source
  a_tick_src: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (src_sel == SCC_SRC_T1 && i_t1_ovf) |=> o_bit_tick)
    else $error("tick source wrong");

  // Hold setting follows the extension bit
  a_hold_ext: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    sda_ext |-> o_sda_hold_cycles == SCC_HOLD_W'(SCC_SDA_HOLD_EXT))
    else $error("extended hold not selected");

  // A START crossing marks the bus busy
  a_start_busy: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (enable && start_ev && !stop_ev && !st.free) |=> st.bus == SCC_LINK_BUSY)
    else $error("START did not set busy");

  // Bus-free timeout ends a transfer
  a_free_idle: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (enable && free_to_en && st.free && st.bus == SCC_LINK_BUSY)
      |=> st.bus == SCC_LINK_IDLE)
    else $error("busy survived the free timeout");

  // No bus-free flag while its detection is off
  a_free_off: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !free_to_en |=> !o_bus_free)
    else $error("bus free flagged while detection off");

  // Disabled interface raises no interrupt, timer reload or bus-free flag
  a_disabled_quiet: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !enable |=> !o_irq_event && !o_timer_reload_hi && !o_bus_free)
    else $error("output active while disabled");

  // An idle selected source gives no tick
  a_tick_quiet: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (src_sel == SCC_SRC_T0 && !i_t0_ovf) |=> !o_bit_tick)
    else $error("tick without its source");

  // Upper byte overflow of timer 2 reaches the tick
  a_tick_upper: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (src_sel == SCC_SRC_T2H && i_t2h_ovf) |=> o_bit_tick)
    else $error("upper byte overflow lost");

  // Without split mode both bytes reload on SCL high
  a_reload_both: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (enable && scl_to_en && st.scl_s[1] && !i_timer_split)
      |=> o_timer_reload_lo)
    else $error("low byte not held in reload");

  // Normal hold when the extension bit is clear
  a_hold_norm: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !sda_ext |-> o_sda_hold_cycles == SCC_HOLD_W'(SCC_SDA_HOLD_NORM))
    else $error("normal hold not selected");
endmodule : scc_config

// ### tb/scc_bus_model.sv
// Far-side bus party: drives SCL and SDA low, or to 1 when released
module scc_bus_model (
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low;
  logic sda_low;
  // A released line is driven to 1, standing in for the pull-up level
  assign o_scl = ~scl_low;
  assign o_sda = ~sda_low;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Pull or release each line
  task automatic set_low(input logic s, input logic d);
    scl_low = s;
    sda_low = d;
  endtask : set_low
  // START: SDA falls while SCL is high, then SCL goes low
  task automatic start_cond();
    set_low(1'b0, 1'b1);
    #800;
    set_low(1'b1, 1'b1);
    #800;
  endtask : start_cond
  // STOP: SCL released first, then SDA rises while SCL high
  task automatic stop_cond();
    set_low(1'b0, 1'b1);
    #800;
    set_low(1'b0, 1'b0);
    #800;
  endtask : stop_cond
endmodule : scc_bus_model

// ### tb/tb_smbus_config_control.sv
// Self-checking bench for the bus configuration block
module tb_smbus_config_control import scc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // Short free count keeps the run brief
  localparam int FREE_N = 2;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } scc_row_t;
  // Register writes and the read-back they should give
  localparam scc_row_t ROWS [5] = '{
    '{8'hC1, 8'h84, 8'h84}, '{8'hC1, 8'hFF, 8'hDF},
    '{8'hC2, 8'h00, 8'hDF}, '{8'hC1, 8'h10, 8'h10},
    '{8'hC1, 8'h00, 8'h00}};
  logic       clk, resetn, link_clk, wr, scl, sda, split;
  logic       slv_ev, mst_ev, irq, rl_hi, rl_lo, tick, mon, free;
  logic [7:0] addr, wdata, rdata, hx;
  logic [3:0] ovf;
  logic [1:0] hold;
  int         error_cnt = 0;
  int         checks_done = 0;

  scc_config #(.FREE_PERIODS(FREE_N)) u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_link_clk(link_clk),
    .i_sfr_wr(wr), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_scl(scl), .i_sda(sda),
    .i_t0_ovf(ovf[0]), .i_t1_ovf(ovf[1]), .i_t2h_ovf(ovf[2]),
    .i_t2l_ovf(ovf[3]), .i_timer_split(split),
    .i_slave_event(slv_ev), .i_master_event(mst_ev),
    .o_irq_event(irq), .o_timer_reload_hi(rl_hi),
    .o_timer_reload_lo(rl_lo), .o_bit_tick(tick),
    .o_monitor_active(mon), .o_sda_hold_cycles(hold), .o_bus_free(free));
  scc_bus_model u_bus (.o_scl(scl), .o_sda(sda));

  // System clock 100 MHz; link clock 160 ns, offset in phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever begin
      link_clk = ~link_clk;
      #80;
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // One-cycle write strobe, driven between edges
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  // Pulse {slave, master, overflows} for one cycle
  task automatic pulse(input logic [5:0] v);
    @(negedge clk);
    {slv_ev, mst_ev, ovf} = v;
    @(negedge clk);
    {slv_ev, mst_ev, ovf} = 6'h00;
  endtask : pulse
  // Bounded wait on the busy bit; a hang ends the run as a failure
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (rdata[SCC_BIT_BUSY] !== v) begin
      @(negedge clk);
      n++;
      if (n > 500) begin
        error_cnt++;
        $display("[ERR] %0t busy wait timed out", $time);
        final_report();
      end
    end
    chk1(rdata[SCC_BIT_BUSY], v);
  endtask : wait_busy

  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ovf = 4'h0;
    split = 1'b0;
    slv_ev = 1'b0;
    mst_ev = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr_reg(ROWS[i].addr, ROWS[i].wdata);
      hx = ROWS[i].exp[SCC_BIT_SDA_EXT] ? 8'(SCC_SDA_HOLD_EXT)
                                        : 8'(SCC_SDA_HOLD_NORM);
      chk8(rdata, ROWS[i].exp);
      chk1(mon, ROWS[i].exp[SCC_BIT_ENABLE]);
      chk8({6'h00, hold}, hx);
    end
    $display("register rows done");
    // Only the selected overflow reaches the bit tick
    for (int s = 0; s < 4; s++) begin
      wr_reg(SCC_ADDR_CFG, 8'h80 | 8'(s));
      for (int o = 0; o < 4; o++) begin
        pulse(6'(1 << o));
        chk1(tick, o == s);
      end
    end
    $display("source select done");
    for (int h = 0; h < 2; h++) begin
      wr_reg(SCC_ADDR_CFG, 8'h80 | 8'(h << 6));
      pulse(6'h20);
      chk1(irq, h == 0);
      pulse(6'h10);
      chk1(irq, 1'b1);
    end
    wr_reg(SCC_ADDR_CFG, 8'h00);
    pulse(6'h10);
    chk1(irq, 1'b0);
    // Disabled block ignores a held-low line
    u_bus.set_low(1'b1, 1'b1);
    repeat (10) @(negedge clk);
    chk1(rdata[SCC_BIT_BUSY], 1'b0);
    u_bus.set_low(1'b0, 1'b0);
    $display("events done");
    wr_reg(SCC_ADDR_CFG, 8'h88);
    repeat (5) @(negedge clk);
    chk1(rl_hi, 1'b1);
    chk1(rl_lo, 1'b1);
    split = 1'b1;
    repeat (5) @(negedge clk);
    chk1(rl_hi, 1'b1);
    chk1(rl_lo, 1'b0);
    u_bus.set_low(1'b1, 1'b0);
    repeat (5) @(negedge clk);
    chk1(rl_hi, 1'b0);
    chk1(rdata[SCC_BIT_BUSY], 1'b1);
    // Software timeout handler drops and restarts the interface
    wr_reg(SCC_ADDR_CFG, 8'h08);
    @(negedge clk);
    chk1(rdata[SCC_BIT_BUSY], 1'b0);
    wr_reg(SCC_ADDR_CFG, 8'h88);
    u_bus.stop_cond();
    wait_busy(1'b0);
    u_bus.start_cond();
    wait_busy(1'b1);
    u_bus.stop_cond();
    wait_busy(1'b0);
    $display("timer and start-stop done");
    // Free count restarts on a low line, then ends busy
    wr_reg(SCC_ADDR_CFG, 8'h84);
    u_bus.set_low(1'b1, 1'b0);
    wait_busy(1'b1);
    u_bus.set_low(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    repeat (FREE_N) pulse(6'h01);
    u_bus.set_low(1'b1, 1'b0);
    repeat (10) @(negedge clk);
    u_bus.set_low(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    repeat (FREE_N) pulse(6'h01);
    repeat (3) @(negedge clk);
    chk1(free, 1'b0);
    pulse(6'h01);
    repeat (3) @(negedge clk);
    chk1(free, 1'b1);
    chk1(rdata[SCC_BIT_BUSY], 1'b0);
    $display("free timeout done");
    wr_reg(SCC_ADDR_CFG, 8'h90);
    resetn = 1'b0;
    repeat (20) @(negedge clk);
    chk8(rdata, SCC_CFG_RESET);
    chk8({6'h00, hold}, 8'(SCC_SDA_HOLD_NORM));
    chk1(free, 1'b0);
    chk1(mon, 1'b0);
    resetn = 1'b1;
    $display("reset done");
    final_report();
  end
endmodule : tb_smbus_config_control
